/* core/uart_baud_gen_rx_status.sv */
/*
 * baud generator and receive status logic with an axi4-lite register
 * slave. assumes the receive pin is asynchronous to aclk and that the
 * master keeps one write and one read in flight at most.
 */
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module uart_baud_gen_rx_status
	import uart_brg_pkg::*;
(
	input  wire logic        aclk,          // 100 MHz oscillator clock
	input  wire logic        aresetn,       // sync reset, active low
	input  wire logic [4:0]  s_axi_awaddr,  // write address
	input  wire logic        s_axi_awvalid, // write address valid
	output logic             s_axi_awready, // write address taken
	input  wire logic [31:0] s_axi_wdata,   // write data
	input  wire logic [3:0]  s_axi_wstrb,   // byte enables
	input  wire logic        s_axi_wvalid,  // write data valid
	output logic             s_axi_wready,  // write data taken
	output logic [1:0]       s_axi_bresp,   // write response
	output logic             s_axi_bvalid,  // write response valid
	input  wire logic        s_axi_bready,  // write response taken
	input  wire logic [4:0]  s_axi_araddr,  // read address
	input  wire logic        s_axi_arvalid, // read address valid
	output logic             s_axi_arready, // read address taken
	output logic [31:0]      s_axi_rdata,   // read data
	output logic [1:0]       s_axi_rresp,   // read response
	output logic             s_axi_rvalid,  // read data valid
	input  wire logic        s_axi_rready,  // read data taken
	input  wire logic        receive_data_pin, // serial input line
	output logic             bit_tick,      // one pulse per bit time
	output logic             irq            // level interrupt
);

	// register state
	logic [7:0]        div_r, div_nxt;        // baud_divisor_reg
	logic              master_r, master_nxt;
	logic              sync_r, sync_nxt;
	logic              hs_r, hs_nxt;          // high_speed_select
	rxsc_t             rxsc_r, rxsc_nxt;
	logic [7:0]        rbuf_r, rbuf_nxt;      // receive_data_buffer
	logic              full_r, full_nxt;
	logic [EV_W-1:0]   ist_r, ist_nxt;
	logic [EV_W-1:0]   imsk_r, imsk_nxt;
	logic              irq_r, irq_nxt;
	// generator state
	logic [7:0]        brg_r, brg_nxt;
	logic [1:0]        pre_r, pre_nxt;
	logic [3:0]        ph_r, ph_nxt;
	logic              tick_r, tick_nxt;
	// receiver state
	logic [2:0]        pin_r, pin_nxt;
	logic              lvl_r, lvl_nxt;
	rx_state_t         st_r, st_nxt;
	logic [3:0]        rph_r, rph_nxt;
	logic [2:0]        vote_r, vote_nxt;
	logic [8:0]        sr_r, sr_nxt;
	logic [3:0]        nbit_r, nbit_nxt;
	// bus state
	logic              awr_r, awr_nxt;
	logic              bval_r, bval_nxt;
	logic [1:0]        bresp_r, bresp_nxt;
	logic              arr_r, arr_nxt;
	logic              rval_r, rval_nxt;
	logic [31:0]       rdata_r, rdata_nxt;
	logic [1:0]        rresp_r, rresp_nxt;

	// decoded helpers
	logic              wr_fire, rd_fire, div_wr, rbuf_rd;
	logic              div4, base_tick, sample_tick, gen_en, rx_en;
	logic              maj, frame_end, bit8_in, drop, load;
	logic [7:0]        byte_in;
	logic [4:0]        waddr, raddr;
	logic [EV_W-1:0]   ev, clr;

	assign waddr = {s_axi_awaddr[4:2], 2'h0};
	assign raddr = {s_axi_araddr[4:2], 2'h0};
	assign wr_fire = awr_r & s_axi_awvalid & s_axi_wvalid;
	assign rd_fire = arr_r & s_axi_arvalid;
	assign div_wr  = wr_fire & s_axi_wstrb[0] & (waddr == OFS_DIVISOR);
	assign rbuf_rd = rd_fire & (raddr == OFS_RXBUF);

	// generator ticks; sync mode forces the 4:1 path whatever hs says
	assign div4        = sync_r | ~hs_r;
	assign base_tick   = (brg_r == div_r);
	assign sample_tick = base_tick & (~div4 | (pre_r == PRE_LAST));
	assign gen_en      = ~sync_r | master_r;
	// continuous receive wins over single receive
	assign rx_en = rxsc_r.port_en &
		(rxsc_r.continuous_receive_enable | (sync_r & rxsc_r.single_receive_enable));

	// majority of the three mid-bit samples
	assign maj = (vote_r[0] & vote_r[1]) | (vote_r[0] & vote_r[2]) |
		(vote_r[1] & vote_r[2]);
	assign frame_end = (st_r == RX_STOP) & sample_tick & (rph_r == PH_LAST);
	assign byte_in   = rxsc_r.rx9 ? sr_r[7:0] : sr_r[8:1];
	assign bit8_in   = rxsc_r.rx9 & sr_r[8];
	assign drop      = rxsc_r.rx9 & rxsc_r.address_detect_enable & ~bit8_in;
	assign load      = frame_end & ~drop & ~full_r;

	// baud generator next state: free-running, cleared by a divisor write
	always_comb begin
		brg_nxt  = brg_r;
		pre_nxt  = pre_r;
		ph_nxt   = ph_r;
		tick_nxt = 1'b0;
		if (div_wr) begin
			brg_nxt = 8'h00;
			pre_nxt = 2'h0;
			ph_nxt  = 4'h0;
		end else if (base_tick) begin
			brg_nxt = 8'h00;
			if (div4)
				pre_nxt = pre_r + 2'h1;
		end else begin
			brg_nxt = brg_r + 8'h01;
		end
		if (sample_tick & ~div_wr)
			ph_nxt = ph_r + 4'h1;
		// async bits span 16 samples, sync bits one
		if (sample_tick & gen_en & (sync_r | (ph_r == PH_LAST)))
			tick_nxt = 1'b1;
	end

	// receiver next state: filtered pin, votes, framing and flags
	always_comb begin
		pin_nxt  = {pin_r[1:0], receive_data_pin};
		// a change counts once the second and third stages agree
		lvl_nxt  = (pin_r[1] == pin_r[2]) ? pin_r[2] : lvl_r;
		st_nxt   = st_r;
		rph_nxt  = rph_r;
		vote_nxt = vote_r;
		sr_nxt   = sr_r;
		nbit_nxt = nbit_r;
		rbuf_nxt = rbuf_r;
		full_nxt = full_r & ~rbuf_rd;
		rxsc_nxt = rxsc_r;
		ev       = '0;
		if (sample_tick) begin
			rph_nxt = rph_r + 4'h1;
			if (rph_r == VOTE_PH0)
				vote_nxt[0] = lvl_r;
			if (rph_r == VOTE_PH1)
				vote_nxt[1] = lvl_r;
			if (rph_r == VOTE_PH2)
				vote_nxt[2] = lvl_r;
		end
		unique case (st_r)
			RX_IDLE: begin
				rph_nxt = 4'h0;
				// reception halts while an overrun is pending
				if (rx_en & ~sync_r & ~rxsc_r.overrun_error_flag & ~lvl_r)
					st_nxt = RX_START;
			end
			RX_START: begin
				if (sample_tick & (rph_r == PH_LAST)) begin
					nbit_nxt = 4'h0;
					// a start bit that votes high was a glitch
					st_nxt = maj ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (sample_tick & (rph_r == PH_LAST)) begin
					sr_nxt   = {maj, sr_r[8:1]};
					nbit_nxt = nbit_r + 4'h1;
					if ((nbit_r + 4'h1) ==
						(rxsc_r.rx9 ? BITS_9 : BITS_8))
						st_nxt = RX_STOP;
				end
			end
			RX_STOP: begin
				if (frame_end)
					st_nxt = RX_IDLE;
			end
		endcase
		if (frame_end & ~drop) begin
			if (full_r) begin
				rxsc_nxt.overrun_error_flag  = 1'b1;
				ev[EV_OVR_BIT] = 1'b1;
			end else begin
				rbuf_nxt        = byte_in;
				rxsc_nxt.received_ninth_bit   = bit8_in;
				rxsc_nxt.framing_error_flag   = ~maj;
				full_nxt        = 1'b1;
				ev[EV_RX_BIT]   = 1'b1;
				ev[EV_FRAMING_ERROR_FLAG_BIT] = ~maj;
			end
		end
		if (~rx_en | sync_r)
			st_nxt = RX_IDLE;
		// software control bits; status bits are read-only
		if (wr_fire & s_axi_wstrb[0] & (waddr == OFS_RXSC)) begin
			rxsc_nxt.port_en = s_axi_wdata[7];
			rxsc_nxt.rx9     = s_axi_wdata[6];
			rxsc_nxt.single_receive_enable    = s_axi_wdata[5];
			rxsc_nxt.continuous_receive_enable    = s_axi_wdata[4];
			rxsc_nxt.address_detect_enable   = s_axi_wdata[3];
		end
		// overrun stays until continuous receive goes low
		if (~rxsc_nxt.continuous_receive_enable)
			rxsc_nxt.overrun_error_flag = 1'b0;
	end

	// bus slave and remaining registers next state
	always_comb begin
		awr_nxt    = awr_r;
		bval_nxt   = bval_r & ~s_axi_bready;
		bresp_nxt  = bresp_r;
		arr_nxt    = arr_r;
		rval_nxt   = rval_r & ~s_axi_rready;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		div_nxt    = div_r;
		master_nxt = master_r;
		sync_nxt   = sync_r;
		hs_nxt     = hs_r;
		imsk_nxt   = imsk_r;
		clr        = '0;
		// both write channels are taken together in one cycle
		if (~awr_r & ~bval_r & s_axi_awvalid & s_axi_wvalid)
			awr_nxt = 1'b1;
		if (wr_fire) begin
			awr_nxt   = 1'b0;
			bval_nxt  = 1'b1;
			bresp_nxt = RESP_OKAY;
			if (s_axi_wstrb[0]) begin
				unique case (waddr)
					OFS_DIVISOR: div_nxt = s_axi_wdata[7:0];
					OFS_TXSC: begin
						master_nxt = s_axi_wdata[TXSC_MASTER_BIT];
						sync_nxt   = s_axi_wdata[TXSC_SYNC_BIT];
						hs_nxt     = s_axi_wdata[TXSC_HS_BIT];
					end
					OFS_IRQ_ST:  clr = s_axi_wdata[EV_W-1:0];
					OFS_IRQ_MSK: imsk_nxt = s_axi_wdata[EV_W-1:0];
					OFS_RXSC, OFS_RXBUF: ;
					default: bresp_nxt = RESP_SLVERR;
				endcase
			end
		end
		if (~arr_r & ~rval_r & s_axi_arvalid)
			arr_nxt = 1'b1;
		if (rd_fire) begin
			arr_nxt   = 1'b0;
			rval_nxt  = 1'b1;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = 32'h0;
			unique case (raddr)
				OFS_DIVISOR: rdata_nxt[7:0] = div_r;
				OFS_TXSC: begin
					rdata_nxt[TXSC_MASTER_BIT] = master_r;
					rdata_nxt[TXSC_SYNC_BIT]   = sync_r;
					rdata_nxt[TXSC_HS_BIT]     = hs_r;
				end
				OFS_RXSC:    rdata_nxt[7:0] = rxsc_r;
				OFS_RXBUF:   rdata_nxt[7:0] = rbuf_r;
				OFS_IRQ_ST:  rdata_nxt[EV_W-1:0] = ist_r;
				OFS_IRQ_MSK: rdata_nxt[EV_W-1:0] = imsk_r;
				default:     rresp_nxt = RESP_SLVERR;
			endcase
		end
		// a new event in the clearing cycle wins over the clear
		ist_nxt = (ist_r & ~clr) | ev;
		irq_nxt = |(ist_nxt & imsk_nxt);
	end

	// one register stage for everything
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_r   <= DIVISOR_RST;
			master_r <= 1'b0;
			sync_r  <= 1'b0;
			hs_r    <= 1'b0;
			rxsc_r  <= RXSC_RST;
			rbuf_r  <= 8'h00;
			full_r  <= 1'b0;
			ist_r   <= '0;
			imsk_r  <= '0;
			irq_r   <= 1'b0;
			brg_r   <= 8'h00;
			pre_r   <= 2'h0;
			ph_r    <= 4'h0;
			tick_r  <= 1'b0;
			pin_r   <= 3'h7;
			lvl_r   <= 1'b1;
			st_r    <= RX_IDLE;
			rph_r   <= 4'h0;
			vote_r  <= 3'h7;
			sr_r    <= 9'h000;
			nbit_r  <= 4'h0;
			awr_r   <= 1'b0;
			bval_r  <= 1'b0;
			bresp_r <= RESP_OKAY;
			arr_r   <= 1'b0;
			rval_r  <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= RESP_OKAY;
		end else begin
			div_r   <= div_nxt;
			master_r <= master_nxt;
			sync_r  <= sync_nxt;
			hs_r    <= hs_nxt;
			rxsc_r  <= rxsc_nxt;
			rbuf_r  <= rbuf_nxt;
			full_r  <= full_nxt;
			ist_r   <= ist_nxt;
			imsk_r  <= imsk_nxt;
			irq_r   <= irq_nxt;
			brg_r   <= brg_nxt;
			pre_r   <= pre_nxt;
			ph_r    <= ph_nxt;
			tick_r  <= tick_nxt;
			pin_r   <= pin_nxt;
			lvl_r   <= lvl_nxt;
			st_r    <= st_nxt;
			rph_r   <= rph_nxt;
			vote_r  <= vote_nxt;
			sr_r    <= sr_nxt;
			nbit_r  <= nbit_nxt;
			awr_r   <= awr_nxt;
			bval_r  <= bval_nxt;
			bresp_r <= bresp_nxt;
			arr_r   <= arr_nxt;
			rval_r  <= rval_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	assign s_axi_awready = awr_r;
	assign s_axi_wready  = awr_r;
	assign s_axi_bvalid  = bval_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arr_r;
	assign s_axi_rvalid  = rval_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign bit_tick      = tick_r;
	assign irq           = irq_r;

	// checking helpers: clocks since the last sample tick, and whether
	// any register was written in that span
	logic [9:0] gap_r;
	logic       dirty_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap_r   <= 10'h000;
			dirty_r <= 1'b1;
		end else begin
			gap_r   <= (sample_tick | div_wr) ? 10'h000 : gap_r + 10'h001;
			// a write on a tick edge taints the span that follows it
			dirty_r <= wr_fire ? 1'b1 :
				(sample_tick ? 1'b0 : dirty_r);
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_SLOW_PERIOD: assert property (sample_tick & ~dirty_r & ~sync_r & ~hs_r
		|-> gap_r == {div_r, 2'h3}) else $error("slow async period wrong");
	AST_FAST_PERIOD: assert property (sample_tick & ~dirty_r & ~sync_r & hs_r
		|-> gap_r == {2'h0, div_r}) else $error("fast async period wrong");
	AST_SYNC_PERIOD: assert property (sample_tick & ~dirty_r & sync_r
		|-> gap_r == {div_r, 2'h3}) else $error("sync period wrong");
	AST_SYNC_HS_IGNORED: assert property (sample_tick & ~dirty_r & sync_r
		& hs_r |-> gap_r == {div_r, 2'h3})
		else $error("high speed bit acts in sync mode");
	AST_HS_FIELD: assert property (wr_fire & s_axi_wstrb[0] & (waddr == OFS_TXSC)
		|=> hs_r == $past(s_axi_wdata[2])) else $error("hs bit misplaced");
	AST_SLAVE_NO_TICK: assert property (sync_r & ~master_r & $past(sync_r)
		& ~$past(master_r) |-> ~bit_tick) else $error("tick in slave mode");
	AST_DIV_CLEARS: assert property (div_wr |=> brg_r == 8'h00 && pre_r == 2'h0
		##1 brg_r <= 8'h01) else $error("divisor write did not clear timer");
	AST_FRAMING_ERROR_FLAG_VOTE: assert property (load |=> rxsc_r.framing_error_flag == ~$past(maj)
		&& full_r) else $error("framing flag not from majority");
	AST_OVERRUN_ERROR_FLAG_HOLD: assert property (rxsc_r.overrun_error_flag & rxsc_nxt.continuous_receive_enable |=> rxsc_r.overrun_error_flag)
		else $error("overrun dropped while receive enabled");
	AST_ADDR_DROP: assert property (frame_end & drop & ~rbuf_rd
		|=> full_r == $past(full_r) && !ist_r[EV_RX_BIT] ||
		$past(ist_r[EV_RX_BIT])) else $error("address byte loaded");

	COV_LOAD:    cover property (load ##[1:100] rbuf_rd);
	COV_OVERRUN: cover property (frame_end & ~drop & full_r);
	COV_FRAMING_ERROR_FLAG:    cover property (load & ~maj);
	COV_IRQ:     cover property (~irq ##1 irq);

endmodule // uart_baud_gen_rx_status

`default_nettype wire

/* core/uart_brg_pkg.sv */
/*
 * constants, register layout and types for the baud generator and
 * receive status block. assumes a 32-bit axi4-lite register bus with
 * one aligned word per register, byte addresses as given below.
 */
`default_nettype none

package uart_brg_pkg;

	// register byte addresses on the axi4-lite bus
	localparam logic [4:0] OFS_DIVISOR = 5'h00; // baud_divisor_reg
	localparam logic [4:0] OFS_TXSC    = 5'h04; // transmit_status_control
	localparam logic [4:0] OFS_RXSC    = 5'h08; // receive_status_control
	localparam logic [4:0] OFS_RXBUF   = 5'h0c; // receive_data_buffer
	localparam logic [4:0] OFS_IRQ_ST  = 5'h10; // sticky events, w1c
	localparam logic [4:0] OFS_IRQ_MSK = 5'h14; // interrupt mask

	// transmit_status_control field positions
	localparam int TXSC_MASTER_BIT = 7; // clock source: 1 = internal
	localparam int TXSC_SYNC_BIT   = 4; // 1 = synchronous mode
	localparam int TXSC_HS_BIT     = 2; // high_speed_select

	// event bit positions in the interrupt status and mask registers
	localparam int EV_RX_BIT   = 0; // byte loaded into the buffer
	localparam int EV_OVR_BIT  = 1; // overrun
	localparam int EV_FRAMING_ERROR_FLAG_BIT = 2; // framing error
	localparam int EV_W        = 3;

	// reset values
	localparam logic [7:0] DIVISOR_RST = 8'h00;
	localparam logic [7:0] RXSC_RST    = 8'h00;

	// generator ratios: base tick every X+1 clocks, then a 4:1 prescale except in high-speed async mode
	localparam logic [1:0] PRE_LAST  = 2'h3; // 64/16 or 4/1, less one
	localparam logic [3:0] PH_LAST   = 4'hf; // 16 samples per async bit
	localparam logic [3:0] VOTE_PH0  = 4'h7; // three votes mid-bit
	localparam logic [3:0] VOTE_PH1  = 4'h8;
	localparam logic [3:0] VOTE_PH2  = 4'h9;
	localparam logic [3:0] BITS_8    = 4'h8;
	localparam logic [3:0] BITS_9    = 4'h9;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// receive_status_control as held in hardware
	typedef struct packed {
		logic port_en;  // serial port enable
		logic rx9;      // nine_bit_receive_select
		logic single_receive_enable;     // single_receive_enable
		logic continuous_receive_enable;     // continuous_receive_enable
		logic address_detect_enable;    // address_detect_enable
		logic framing_error_flag;     // framing_error_flag
		logic overrun_error_flag;     // overrun_error_flag
		logic received_ninth_bit;     // received_ninth_bit
	} rxsc_t;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

`default_nettype wire

/* verification/serial_line_model.sv */
/*
 * serial line model: the remote transmitter that drives the receive pin.
 * assumes the bench passes the clocks per bit that it configured.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_line_model (
	input  wire logic aclk, // bench clock
	output var logic  line  // drives the receive pin
);
	// the line rests high between frames, as a released uart line does
	initial line = 1'b1;

	// one frame: start, nb data bits lsb first, stop, two idle bit times;
	// glitch flips one clock mid-bit, which pin filter and vote must reject
	task automatic send(input logic [8:0] dat, input int nb,
		input logic stop, input int cpb, input logic glitch);
		logic b;
		int   i;
		int   c;
		for (i = 0; i < nb + 4; i++) begin
			for (c = 0; c < cpb; c++) begin
				b = (i == 0) ? 1'b0 : (i <= nb) ? dat[i-1] :
					(i == nb + 1) ? stop : 1'b1;
				@(posedge aclk);
				line <= (glitch && c == cpb / 2 && i > 0 && i <= nb) ? ~b : b;
			end
		end
	endtask
endmodule // serial_line_model

`default_nettype wire

/* verification/tb_top.sv */
/*
 * self-checking bench: axi4-lite master tasks, bit timing and receive
 * scenarios. assumes the line model supplies every received frame.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
	$display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end

module tb_top;
	import uart_brg_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, rxd, tick, irq;
	logic [1:0]  bresp, rresp, resp;
	int          failures = 0, checked = 0, p, k, n2;
	logic [7:0]  cfg_tx [5] = '{8'h80, 8'h84, 8'h90, 8'h94, 8'h84};
	logic [7:0]  cfg_x [5] = '{8'h01, 8'h02, 8'h03, 8'h03, 8'hff};
	int          cfg_p [5] = '{128, 48, 16, 16, 4096};

	always #5 aclk = ~aclk;

	uart_baud_gen_rx_status u_uart_baud_gen_rx_status (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .receive_data_pin(rxd),
		.bit_tick(tick), .irq(irq));

	serial_line_model u_serial_line_model (.aclk(aclk), .line(rxd));

	task automatic wrap_up();
		if (failures == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// address and data go out together and drop once taken
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin @(posedge aclk); n++; end
		while (awready !== 1'b1 && n < 1000);
		`CHK(wready, 1'b1)
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do begin @(posedge aclk); n++; end
		while (bvalid !== 1'b1 && n < 1000);
		resp = bresp;
		bready <= 1'b0;
		if (n >= 1000) failures++;
	endtask

	task automatic rd(input logic [4:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin @(posedge aclk); n++; end
		while (arready !== 1'b1 && n < 1000);
		arvalid <= 1'b0;
		do begin @(posedge aclk); n++; end
		while (rvalid !== 1'b1 && n < 1000);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (n >= 1000) failures++;
	endtask

	task automatic rchk(input logic [4:0] a, input logic [7:0] e);
		rd(a);
		`CHK(d, {24'h0, e})
		`CHK(resp, RESP_OKAY)
	endtask

	// clocks from one bit tick to the next, bounded
	task automatic per(output int q);
		int n;
		n = 0;
		do begin @(posedge aclk); n++; end
		while (tick !== 1'b1 && n < 9000);
		q = 0;
		do begin @(posedge aclk); q++; end
		while (tick !== 1'b1 && q < 9000);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic rx(input logic [8:0] v, input int nb, input logic s);
		u_serial_line_model.send(v, nb, s, 16, 1'b0);
	endtask

	// watchdog: the whole run needs well under 60000 clocks
	initial begin
		#600000;
		failures++;
		wrap_up();
	end

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(OFS_DIVISOR, DIVISOR_RST);
		rchk(OFS_TXSC, 8'h00);
		rchk(OFS_RXSC, RXSC_RST);
		rchk(OFS_IRQ_MSK, 8'h00);
		rchk(OFS_IRQ_ST, 8'h00);
		wr(5'h18, 32'h1);
		`CHK(resp, RESP_SLVERR)
		rd(5'h18);
		`CHK(resp, RESP_SLVERR)
		`CHK(d, 32'h0)
		// every rate mode; the second period is taken, clear of restarts
		for (k = 0; k < 5; k++) begin
			wr(OFS_DIVISOR, {24'h0, cfg_x[k]});
			wr(OFS_TXSC, {24'h0, cfg_tx[k]});
			per(p);
			per(p);
			`CHK(p, cfg_p[k])
		end
		rchk(OFS_DIVISOR, 8'hff);
		// a write with byte lane 0 off must leave the divisor alone
		wstrb <= 4'he;
		wr(OFS_DIVISOR, 32'h0);
		`CHK(resp, RESP_OKAY)
		wstrb <= 4'hf;
		rchk(OFS_DIVISOR, 8'hff);
		// a divisor write must not wait out the 4096-clock count
		per(p);
		wr(OFS_DIVISOR, 32'h0);
		p = 0;
		while (tick !== 1'b1 && p < 5000) begin @(posedge aclk); p++; end
		`CHK(p <= 24, 1'b1)
		// slave: no internal bit clock at all
		wr(OFS_TXSC, 32'h10);
		idle(4);
		n2 = 0;
		repeat (300) begin @(posedge aclk); if (tick === 1'b1) n2++; end
		`CHK(n2, 0)
		// receive at 16 clocks per bit, interrupt masked first
		wr(OFS_TXSC, 32'h84);
		wr(OFS_RXSC, 32'h90);
		u_serial_line_model.send(9'h0a5, 8, 1'b1, 16, 1'b1);
		`CHK(irq, 1'b0)
		rchk(OFS_IRQ_ST, 8'h01);
		wr(OFS_IRQ_MSK, 32'h7);
		idle(2);
		`CHK(irq, 1'b1)
		rchk(OFS_RXBUF, 8'ha5);
		wr(OFS_IRQ_ST, 32'h1);
		idle(2);
		`CHK(irq, 1'b0)
		rx(9'h05a, 8, 1'b0);
		rchk(OFS_RXSC, 8'h94);
		rchk(OFS_IRQ_ST, 8'h05);
		rchk(OFS_RXBUF, 8'h5a);
		rx(9'h011, 8, 1'b1);
		rchk(OFS_RXSC, 8'h90);
		rchk(OFS_RXBUF, 8'h11);
		// overrun: the second byte is lost and reception stops
		wr(OFS_IRQ_ST, 32'h7);
		rx(9'h022, 8, 1'b1);
		rx(9'h033, 8, 1'b1);
		rchk(OFS_RXSC, 8'h92);
		rchk(OFS_IRQ_ST, 8'h03);
		rchk(OFS_RXBUF, 8'h22);
		wr(OFS_IRQ_ST, 32'h7);
		rx(9'h044, 8, 1'b1);
		rchk(OFS_IRQ_ST, 8'h00);
		rchk(OFS_RXSC, 8'h92);
		wr(OFS_RXSC, 32'h80);
		rchk(OFS_RXSC, 8'h80);
		// nine-bit address detect, single receive set beside continuous
		wr(OFS_RXSC, 32'hf8);
		rx(9'h055, 9, 1'b1);
		rchk(OFS_IRQ_ST, 8'h00);
		rx(9'h1a7, 9, 1'b1);
		rchk(OFS_IRQ_ST, 8'h01);
		rchk(OFS_RXSC, 8'hf9);
		rchk(OFS_RXBUF, 8'ha7);
		wrap_up();
	end
endmodule // tb_top

`default_nettype wire
